// File: include/crossbar_pkg.sv
// shared constants and types for the priority crossbar and port configuration
package crossbar_pkg;

	// ------------------------------------------------------------
	// geometry
	// ------------------------------------------------------------
	localparam int NUM_PINS = 17;
	localparam int XBAR_PINS = 16;
	localparam int NUM_SLOTS = 15;
	localparam int SLOT_W = 4;
	localparam int UART_TX_PIN = 4;
	localparam int UART_RX_PIN = 5;
	localparam int SYNC_STAGES = 2;

	// ------------------------------------------------------------
	// slot order, highest priority first after the fixed uart pair
	// ------------------------------------------------------------
	localparam int SLOT_SCK = 0;
	localparam int SLOT_MISO = 1;
	localparam int SLOT_MOSI = 2;
	localparam int SLOT_NSS = 3;
	localparam int SLOT_SDA = 4;
	localparam int SLOT_SCL = 5;
	localparam int SLOT_CMP = 6;
	localparam int SLOT_CMP_ASYNC = 7;
	localparam int SLOT_SYSCLK = 8;
	localparam int SLOT_PCA0 = 9;
	localparam int SLOT_PCA1 = 10;
	localparam int SLOT_PCA2 = 11;
	localparam int SLOT_ECI = 12;
	localparam int SLOT_T0 = 13;
	localparam int SLOT_T1 = 14;

	// ------------------------------------------------------------
	// pca output count encoding
	// ------------------------------------------------------------
	localparam logic [1:0] PCA_NONE = 2'h0;
	localparam logic [1:0] PCA_ONE = 2'h1;
	localparam logic [1:0] PCA_THREE = 2'h3;

	// ------------------------------------------------------------
	// values after reset
	// ------------------------------------------------------------
	localparam logic [NUM_PINS-1:0] INPUT_MODE_RST = 17'h1ffff;
	localparam logic [NUM_PINS-1:0] OUTPUT_MODE_RST = 17'h00000;
	localparam logic [XBAR_PINS-1:0] SKIP_RST = 16'h0000;
	localparam logic [NUM_PINS-1:0] LATCH_RST = 17'h1ffff;

	typedef struct packed {
		logic uart_en;
		logic spi_en;
		logic spi_four_wire;
		logic smbus_en;
		logic cmp_en;
		logic cmp_async_en;
		logic sysclk_en;
		logic [1:0] pca_mode;
		logic eci_en;
		logic t0_en;
		logic t1_en;
	} routing_sel_s;

	typedef struct packed {
		logic [NUM_PINS-1:0] input_mode;
		logic [NUM_PINS-1:0] output_mode;
		logic [XBAR_PINS-1:0] skip;
		logic [NUM_PINS-1:0] latch;
		logic crossbar_enable;
		logic pullup_disable;
	} port_cfg_s;

	localparam routing_sel_s ROUTING_RST = '0;
	localparam port_cfg_s CFG_RST = '{INPUT_MODE_RST, OUTPUT_MODE_RST,
		SKIP_RST, LATCH_RST, 1'b0, 1'b0};

endpackage

// File: design/lowest_free_pick.sv
// picks the least significant free pin for one crossbar slot
module lowest_free_pick
#(
	parameter int WIDTH = 16
)
(
	input wire logic i_request,
	input wire logic [WIDTH-1:0] i_free,
	output logic [WIDTH-1:0] o_grant,
	output logic [WIDTH-1:0] o_free_next
);

	// two's complement isolates the lowest set bit
	wire logic [WIDTH-1:0] lowest = i_free & (~i_free + {{(WIDTH-1){1'b0}}, 1'b1});

	assign o_grant = i_request ? lowest : '0;
	assign o_free_next = i_free & ~o_grant;

endmodule // lowest_free_pick

// File: design/priority_crossbar_port_config.sv
// priority crossbar decoder with per-pin input, output and pull-up control
// Function
// - uart transmit always on P0.4, receive on P0.5 when uart routed
// - nothing skipped: spi clock, miso, mosi, nss land on P0.0 to P0.3
// - skipped pins passed over; example skip lands spi on P0.1,P0.6,P0.7,P1.0
// - three pca outputs take next free unskipped pins after spi
// - slave select routed and consumes a pin only in four-wire spi
// - unclaimed pins stay general-purpose port i/o
// - analog input disables pull-up, output driver and input receiver
// - input mode bit one means digital, zero means analog
// - every pin comes out of reset in digital input mode
// - output mode bit picks open-drain or push-pull; routing changes it only on smbus pins
// - smbus data and clock pins always open-drain
// - pull-up on open-drain pins while pull-up disable is zero; none push-pull
// - pull-up switched off while the pin drives zero
// - routing active only with crossbar enable; else pins are plain inputs
// - all output drivers disabled while crossbar disabled
// - each enabled resource after the fixed uart pair, in priority order, gets lowest free unskipped pin
// - skipped pins treated exactly as already assigned
// - smbus claims data and clock together; uart claims both pins
module priority_crossbar_port_config
	import crossbar_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_srst,
	input wire logic i_clock_en,
	input wire crossbar_pkg::routing_sel_s i_routing,
	input wire crossbar_pkg::port_cfg_s i_cfg,
	input wire logic [crossbar_pkg::NUM_PINS-1:0] i_pin_level,
	input wire logic i_uart_tx,
	input wire logic [crossbar_pkg::NUM_SLOTS-1:0] i_periph_out,
	input wire logic [crossbar_pkg::NUM_SLOTS-1:0] i_periph_oe,
	output logic [crossbar_pkg::NUM_PINS-1:0] o_pin_out,
	output logic [crossbar_pkg::NUM_PINS-1:0] o_pin_oe,
	output logic [crossbar_pkg::NUM_PINS-1:0] o_pullup_en,
	output logic [crossbar_pkg::NUM_PINS-1:0] o_receiver_en,
	output logic [crossbar_pkg::NUM_PINS-1:0] o_pin_in,
	output logic o_uart_rx,
	output logic [crossbar_pkg::NUM_SLOTS-1:0] o_periph_in,
	output logic [crossbar_pkg::XBAR_PINS-1:0] o_pin_claimed
);
	import crossbar_pkg::*;

	// ------------------------------------------------------------
	// configuration and pin synchronisers
	// ------------------------------------------------------------
	routing_sel_s routing_ff;
	port_cfg_s cfg_ff;
	logic [NUM_PINS-1:0] sync1_ff;
	logic [NUM_PINS-1:0] sync2_ff;

	always_ff @(posedge i_clock)
	begin
		if (i_srst)
		begin
			routing_ff <= ROUTING_RST;
			cfg_ff <= CFG_RST;
			sync1_ff <= '0;
			sync2_ff <= '0;
		end
		else if (i_clock_en)
		begin
			routing_ff <= i_routing;
			cfg_ff <= i_cfg;
			sync1_ff <= i_pin_level;
			sync2_ff <= sync1_ff;
		end
	end

	// ------------------------------------------------------------
	// slot requests
	// ------------------------------------------------------------
	wire logic spi_on = routing_ff.spi_en;
	wire logic pca_ge2 = routing_ff.pca_mode[1];
	logic [NUM_SLOTS-1:0] request;

	assign request[SLOT_SCK] = spi_on;
	assign request[SLOT_MISO] = spi_on;
	assign request[SLOT_MOSI] = spi_on;
	assign request[SLOT_NSS] = spi_on & routing_ff.spi_four_wire;
	assign request[SLOT_SDA] = routing_ff.smbus_en;
	assign request[SLOT_SCL] = routing_ff.smbus_en;
	assign request[SLOT_CMP] = routing_ff.cmp_en;
	assign request[SLOT_CMP_ASYNC] = routing_ff.cmp_async_en;
	assign request[SLOT_SYSCLK] = routing_ff.sysclk_en;
	assign request[SLOT_PCA0] = routing_ff.pca_mode != PCA_NONE;
	assign request[SLOT_PCA1] = pca_ge2;
	assign request[SLOT_PCA2] = routing_ff.pca_mode == PCA_THREE;
	assign request[SLOT_ECI] = routing_ff.eci_en;
	assign request[SLOT_T0] = routing_ff.t0_en;
	assign request[SLOT_T1] = routing_ff.t1_en;

	// ------------------------------------------------------------
	// allocation chain
	// ------------------------------------------------------------
	// skipped pins start out taken, and the uart pair is taken whatever
	// the skip mask holds, so later slots see both the same way
	wire logic [XBAR_PINS-1:0] uart_pins =
		routing_ff.uart_en ? 16'h0030 : 16'h0000;
	logic [XBAR_PINS-1:0] free_chain [NUM_SLOTS+1];
	logic [XBAR_PINS-1:0] grant [NUM_SLOTS];

	assign free_chain[0] = ~cfg_ff.skip & ~uart_pins;

	genvar s;
	generate
		for (s = 0; s < NUM_SLOTS; s++)
		begin : g_slot
			lowest_free_pick #(.WIDTH(XBAR_PINS)) u_pick (
				.i_request(request[s]),
				.i_free(free_chain[s]),
				.o_grant(grant[s]),
				.o_free_next(free_chain[s+1])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// per-pin owner lookup
	// ------------------------------------------------------------
	logic [XBAR_PINS-1:0] claimed;
	logic [SLOT_W-1:0] owner [XBAR_PINS];

	always_comb
	begin
		for (int p = 0; p < XBAR_PINS; p++)
		begin
			claimed[p] = 1'b0;
			owner[p] = '0;
			for (int k = 0; k < NUM_SLOTS; k++)
			begin
				if (grant[k][p])
				begin
					claimed[p] = 1'b1;
					owner[p] = SLOT_W'(k);
				end
			end
		end
	end

	// ------------------------------------------------------------
	// per-pin driver, pull-up and receiver
	// ------------------------------------------------------------
	wire logic xbar_on = cfg_ff.crossbar_enable;
	logic [NUM_PINS-1:0] nxt_pin_out;
	logic [NUM_PINS-1:0] nxt_pin_oe;
	logic [NUM_PINS-1:0] nxt_pullup_en;
	logic [NUM_PINS-1:0] routed;
	logic [NUM_PINS-1:0] open_drain;
	logic [NUM_PINS-1:0] want_oe;

	genvar p;
	generate
		for (p = 0; p < NUM_PINS; p++)
		begin : g_pin
			wire logic digital = cfg_ff.input_mode[p];
			wire logic is_uart_tx = (p == UART_TX_PIN) && routing_ff.uart_en;
			wire logic is_uart_rx = (p == UART_RX_PIN) && routing_ff.uart_en;
			if (p < XBAR_PINS)
			begin : g_xbar
				wire logic [SLOT_W-1:0] own = owner[p];
				wire logic smb = claimed[p] &&
					(own == SLOT_W'(SLOT_SDA) || own == SLOT_W'(SLOT_SCL));
				assign routed[p] = xbar_on & claimed[p];
				assign open_drain[p] = ~cfg_ff.output_mode[p] | smb;
				assign nxt_pin_out[p] = is_uart_tx ? i_uart_tx :
					routed[p] ? i_periph_out[own] : cfg_ff.latch[p];
				// uart receive is an input only, so its pin never drives
				assign want_oe[p] = is_uart_rx ? 1'b0 :
					is_uart_tx ? 1'b1 :
					routed[p] ? i_periph_oe[own] : 1'b1;
			end
			else
			begin : g_gpio
				assign routed[p] = 1'b0;
				assign open_drain[p] = ~cfg_ff.output_mode[p];
				assign nxt_pin_out[p] = cfg_ff.latch[p];
				assign want_oe[p] = 1'b1;
			end
			// open-drain only sinks: enable follows a low output value
			assign nxt_pin_oe[p] = xbar_on & digital & want_oe[p] &
				(~open_drain[p] | ~nxt_pin_out[p]);
			assign nxt_pullup_en[p] = ~cfg_ff.pullup_disable & digital &
				open_drain[p] & ~(nxt_pin_oe[p] & ~nxt_pin_out[p]);
		end
	endgenerate

	// ------------------------------------------------------------
	// inputs returned to peripherals
	// ------------------------------------------------------------
	logic [NUM_SLOTS-1:0] nxt_periph_in;

	always_comb
	begin
		for (int k = 0; k < NUM_SLOTS; k++)
		begin
			// idle high so an unrouted input looks like a released line
			nxt_periph_in[k] = 1'b1;
			for (int q = 0; q < XBAR_PINS; q++)
			begin
				if (grant[k][q] && xbar_on && cfg_ff.input_mode[q])
				begin
					nxt_periph_in[k] = sync2_ff[q];
				end
			end
		end
	end

	wire logic nxt_uart_rx = (xbar_on && routing_ff.uart_en &&
		cfg_ff.input_mode[UART_RX_PIN]) ? sync2_ff[UART_RX_PIN] : 1'b1;

	// ------------------------------------------------------------
	// output registers
	// ------------------------------------------------------------
	always_ff @(posedge i_clock)
	begin
		if (i_srst)
		begin
			o_pin_out <= LATCH_RST;
			o_pin_oe <= '0;
			o_pullup_en <= '0;
			o_receiver_en <= INPUT_MODE_RST;
			o_pin_in <= '0;
			o_uart_rx <= 1'b1;
			o_periph_in <= '1;
			o_pin_claimed <= '0;
		end
		else if (i_clock_en)
		begin
			o_pin_out <= nxt_pin_out;
			o_pin_oe <= nxt_pin_oe;
			o_pullup_en <= nxt_pullup_en;
			o_receiver_en <= cfg_ff.input_mode;
			o_pin_in <= sync2_ff & cfg_ff.input_mode;
			o_uart_rx <= nxt_uart_rx;
			o_periph_in <= nxt_periph_in;
			o_pin_claimed <= xbar_on ? (claimed | uart_pins) : '0;
		end
	end

endmodule // priority_crossbar_port_config

// File: test/pin_board.sv
// board model: drivers, weak pull-ups and floating lines on the port pins
module pin_board
(
	input wire logic i_clock,
	input wire logic [crossbar_pkg::NUM_PINS-1:0] i_drive_val,
	input wire logic [crossbar_pkg::NUM_PINS-1:0] i_drive_en,
	input wire logic [crossbar_pkg::NUM_PINS-1:0] i_pull_en,
	input wire logic [crossbar_pkg::NUM_PINS-1:0] i_ext_en,
	input wire logic [crossbar_pkg::NUM_PINS-1:0] i_ext_val,
	output logic [crossbar_pkg::NUM_PINS-1:0] o_level
);
	timeunit 1ns;
	timeprecision 1ps;
	import crossbar_pkg::*;
	// an undriven, unpulled line toggles so a stale value never passes
	logic [NUM_PINS-1:0] float_ff = 17'h0aaaa;
	always @(posedge i_clock) float_ff <= ~float_ff;
	// an outside driver only shows where the device lets the pin go
	assign o_level = (i_drive_en & i_drive_val) |
		(~i_drive_en & i_ext_en & i_ext_val) |
		(~i_drive_en & ~i_ext_en & i_pull_en) |
		(~i_drive_en & ~i_ext_en & ~i_pull_en & float_ff);
endmodule // pin_board

// File: test/xbar_asserts.sv
// concurrent checks on the crossbar port block outputs
module xbar_chk
(
	input wire logic i_clock,
	input wire logic i_srst,
	input wire crossbar_pkg::routing_sel_s i_routing,
	input wire crossbar_pkg::port_cfg_s i_cfg,
	input wire logic i_uart_tx,
	input wire logic [crossbar_pkg::NUM_PINS-1:0] o_pin_out,
	input wire logic [crossbar_pkg::NUM_PINS-1:0] o_pin_oe,
	input wire logic [crossbar_pkg::NUM_PINS-1:0] o_pullup_en,
	input wire logic [crossbar_pkg::NUM_PINS-1:0] o_receiver_en,
	input wire logic [crossbar_pkg::XBAR_PINS-1:0] o_pin_claimed
);
	timeunit 1ns;
	timeprecision 1ps;
	import crossbar_pkg::*;
	// past-value checks must not look into a reset
	logic [1:0] rst_ff;
	logic quiet;
	always_ff @(posedge i_clock) rst_ff <= {rst_ff[0], i_srst};
	assign quiet = (rst_ff == 2'h0);
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_srst);
	property p_ana_oe; (o_pin_oe & ~o_receiver_en) == '0; endproperty
	a_ana_oe: assert property (p_ana_oe) else $error("analog oe");
	property p_ana_pu; (o_pullup_en & ~o_receiver_en) == '0; endproperty
	a_ana_pu: assert property (p_ana_pu) else $error("analog pu");
	property p_pu_low; (o_pullup_en & o_pin_oe & ~o_pin_out) == '0;
	endproperty
	a_pu_low: assert property (p_pu_low) else $error("pu on low");
	property p_off_oe; !$past(i_cfg.crossbar_enable, 2) |-> o_pin_oe == '0;
	endproperty
	a_off_oe: assert property (p_off_oe) else $error("oe while off");
	property p_off_cl;
		!$past(i_cfg.crossbar_enable, 2) |-> o_pin_claimed == '0;
	endproperty
	a_off_cl: assert property (p_off_cl) else $error("claim off");
	property p_pud; $past(i_cfg.pullup_disable, 2) |-> o_pullup_en == '0;
	endproperty
	a_pud: assert property (p_pud) else $error("pu disabled");
	property p_skip;
		(o_pin_claimed & $past(i_cfg.skip, 2) & 16'hffcf) == '0;
	endproperty
	a_skip: assert property (p_skip) else $error("skipped claimed");
	property p_rx; $past(i_routing.uart_en, 2) |-> !o_pin_oe[5]; endproperty
	a_rx: assert property (p_rx) else $error("rx driven");
	property p_tx;
		quiet && $past(i_routing.uart_en && i_cfg.crossbar_enable &&
		i_cfg.input_mode[4] && i_cfg.output_mode[4], 2) |->
		o_pin_oe[4] && o_pin_out[4] == $past(i_uart_tx);
	endproperty
	a_tx: assert property (p_tx) else $error("tx pin");
	property p_p2;
		quiet && $past(i_cfg.crossbar_enable && i_cfg.input_mode[16] &&
		i_cfg.output_mode[16], 2) |->
		o_pin_oe[16] && o_pin_out[16] == $past(i_cfg.latch[16], 2);
	endproperty
	a_p2: assert property (p_p2) else $error("last pin gpio");
	c_full: cover property (o_pin_claimed == 16'hffff);
	c_tx: cover property (o_pin_oe[4] && !o_pin_out[4]);
	c_pu: cover property (o_pullup_en[0] && !o_pin_oe[0]);
endmodule // xbar_chk
bind priority_crossbar_port_config xbar_chk u_chk (.i_clock(i_clock),
	.i_srst(i_srst), .i_routing(i_routing), .i_cfg(i_cfg),
	.i_uart_tx(i_uart_tx), .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe),
	.o_pullup_en(o_pullup_en), .o_receiver_en(o_receiver_en),
	.o_pin_claimed(o_pin_claimed));

// File: test/priority_crossbar_port_config_tb.sv
// self-checking bench for the crossbar port block
module priority_crossbar_port_config_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import crossbar_pkg::*;
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
	bad_count++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
	typedef struct packed {
		routing_sel_s rt;
		logic [15:0] sk;
		logic [15:0] cl;
	} row_s;
	logic clk = 1'b0;
	logic srst = 1'b1;
	routing_sel_s rt = '0;
	port_cfg_s cfg = CFG_RST;
	logic tx = 1'b1;
	logic [NUM_SLOTS-1:0] p_out = '1;
	logic [NUM_SLOTS-1:0] p_oe = '1;
	logic [NUM_PINS-1:0] lvl, pout, poe, pu, rcv, pin;
	logic [XBAR_PINS-1:0] claim;
	logic ce = 1'b1;
	logic rx;
	logic [NUM_SLOTS-1:0] pin_per;
	logic [NUM_PINS-1:0] ext_en = '0;
	logic [NUM_PINS-1:0] ext_val = '0;
	int bad_count = 0;
	int samples_checked = 0;
	int cycles = 0;
	row_s rows [9] = '{'{12'he18, 16'h0000, 16'h01ff},
		'{12'he18, 16'h000d, 16'h0ff2}, '{12'hc18, 16'h0000, 16'h00ff},
		'{12'hfff, 16'h0000, 16'hffff}, '{12'h001, 16'h7fff, 16'h8000},
		'{12'h100, 16'h0001, 16'h0006}, '{12'h800, 16'h0030, 16'h0030},
		'{12'h010, 16'h0000, 16'h0003}, '{12'h008, 16'h0000, 16'h0001}};
	always #2.5 clk = ~clk;
	priority_crossbar_port_config u_dut (.i_clock(clk), .i_srst(srst),
		.i_clock_en(ce), .i_routing(rt), .i_cfg(cfg), .i_pin_level(lvl),
		.i_uart_tx(tx), .i_periph_out(p_out), .i_periph_oe(p_oe),
		.o_pin_out(pout), .o_pin_oe(poe), .o_pullup_en(pu),
		.o_receiver_en(rcv), .o_pin_in(pin), .o_uart_rx(rx),
		.o_periph_in(pin_per), .o_pin_claimed(claim));
	pin_board u_board (.i_clock(clk), .i_drive_val(pout), .i_drive_en(poe),
		.i_pull_en(pu), .i_ext_en(ext_en), .i_ext_val(ext_val),
		.o_level(lvl));
	task automatic finish_test();
		$display("checked %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// six cycles cover config latency plus the pin sync path
	task automatic run(input logic [11:0] r, input logic [16:0] im, om,
		input logic [15:0] sk, input logic [16:0] la, input logic xe, pd);
		rt = r;
		cfg = '{im, om, sk, la, xe, pd};
		repeat (6) @(negedge clk);
	endtask
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 1000)
		begin
			bad_count++;
			finish_test();
		end
	end
	initial
	begin
		repeat (6) @(negedge clk);
		srst = 1'b0;
		run(12'h000, '1, '1, '0, '1, 1'b0, 1'b0);
		for (int i = 0; i < 9; i++)
		begin
			run(rows[i].rt, '1, '1, rows[i].sk, '1, 1'b1, 1'b0);
			`CHK(claim, rows[i].cl)
		end
		$display("done table");
		run(12'hfff, '1, '1, '0, '1, 1'b0, 1'b0);
		`CHK(poe, 17'h0)
		`CHK(claim, 16'h0)
		$display("done crossbar off");
		run(12'h000, '1, '1, '0, 17'h0ffff, 1'b1, 1'b0);
		`CHK(poe, 17'h1ffff)
		`CHK(pin, 17'h0ffff)
		`CHK(pu, 17'h0)
		$display("done push-pull");
		run(12'h000, '1, '0, '0, 17'h0ff00, 1'b1, 1'b0);
		`CHK(poe, 17'h100ff)
		`CHK(pu, 17'h0ff00)
		`CHK(pin, 17'h0ff00)
		run(12'h000, '1, '0, '0, 17'h0ff00, 1'b1, 1'b1);
		`CHK(pu, 17'h0)
		$display("done open-drain");
		run(12'h000, 17'h1fff3, 17'h8, 16'hc, '1, 1'b1, 1'b0);
		`CHK(rcv, 17'h1fff3)
		`CHK(poe, 17'h0)
		`CHK(pu, 17'h1fff3)
		`CHK(pin, 17'h1fff3)
		$display("done analog");
		run(12'h100, '1, '1, '0, '1, 1'b1, 1'b0);
		`CHK(poe, 17'h1fffc)
		`CHK(pu, 17'h00003)
		$display("done open-drain pair");
		// outside circuit pulls the receive pin and the miso pin low
		ext_en = 17'h00022;
		tx = 1'b0;
		run(12'h800, '1, '1, '0, '1, 1'b1, 1'b0);
		`CHK(poe[5:4], 2'b01)
		`CHK(pin[4], 1'b0)
		`CHK(rx, 1'b0)
		p_out = 15'h0005;
		p_oe = 15'h7ffd;
		run(12'h400, '1, '1, '0, '1, 1'b1, 1'b0);
		`CHK(pout[2:0], 3'b101)
		`CHK(poe[2:0], 3'b101)
		`CHK(pin_per[1], 1'b0)
		`CHK(rx, 1'b1)
		$display("done peripheral data");
		// only low latch bits change, so the checker's history stays valid
		ce = 1'b0;
		run(12'h400, '1, '1, '0, 17'h1fff0, 1'b1, 1'b0);
		`CHK(pout[3], 1'b1)
		ce = 1'b1;
		repeat (3) @(negedge clk);
		`CHK(pout[3], 1'b0)
		$display("done clock enable");
		srst = 1'b1;
		repeat (2) @(negedge clk);
		`CHK(poe, 17'h0)
		`CHK(rcv, 17'h1ffff)
		srst = 1'b0;
		$display("done reset");
		finish_test();
	end
endmodule // priority_crossbar_port_config_tb
